// ==== core/wwd_cfg.svh ====
// Purpose: offsets, field positions, reset values and codes of the watchdog
// Assumes: 8-bit register port, 3-bit word address
// Notes:   definitions only
`ifndef WWD_CFG_SVH
`define WWD_CFG_SVH

// register word addresses
`define WWD_ADDR_CTRL0      3'h0
`define WWD_ADDR_CTRL1      3'h1
`define WWD_ADDR_STATUS     3'h2
`define WWD_ADDR_CAUSE      3'h3

// control register zero fields
`define WWD_C0_RUN_BIT      0
`define WWD_C0_IVL_LSB      1
`define WWD_C0_IVL_MSB      5

// status register fields
`define WWD_ST_ACTIVE_BIT   0
`define WWD_ST_ASLEEP_BIT   1
`define WWD_ST_ARMED_BIT    2

// reset cause register fields, all active low
`define WWD_CA_SLEEP_BIT    0
`define WWD_CA_EXPIRY_BIT   1
`define WWD_CA_WDRST_BIT    2
`define WWD_CA_SPAN_BIT     3

// interval select codes and prescale arithmetic
`define WWD_IVL_ALL_ONES    5'h1f
`define WWD_IVL_DEFAULT     5'h0b
`define WWD_IVL_MAX_VALID   5'h12
`define WWD_IVL_MIN         5'h00
`define WWD_IVL_BASE_SHIFT  5'h05
`define WWD_EIGHTH_SHIFT    5'h03

// open span codes
`define WWD_SPAN_FULL       3'h7

// mode fuse codes
`define WWD_MODE_OFF        2'h0
`define WWD_MODE_SOFT       2'h1
`define WWD_MODE_AWAKE      2'h2
`define WWD_MODE_ALWAYS     2'h3

`endif

// ==== core/wwd_core.sv ====
// Purpose: windowed watchdog with fuse modes, window and sleep wake
// Assumes: all inputs synchronous to core_clk; firmware-only register port
// Notes:   reset and wake requests are one-cycle pulses to the system
// Behaviour
// - mode 11 counts always, sleep included
// - mode 10 counts awake, stops in sleep
// - mode 01 follows software run enable bit
// - mode 00 never counts
// - interval code n gives 2^(5+n) prescale
// - reserved interval codes give minimum interval
// - interval resets to fuse value or default
// - interval read-only unless fuse all ones
// - slow oscillator ticks form the time base
// - kick outside open share resets device
// - span from fuse, or register if 111
// - violation clears span flag; firmware sets it
// - counter cleared on listed events
// - kick needs prior arming read in windowed mode
// - sleep entry and exit clear; settle holds zero
// - expiry in sleep wakes, updates flags, no reset
// - divider changes leave counter alone
// - awake expiry without kick resets device
// - span code sets open share in eighths
// - armed status bit is readable
`timescale 1ns/1ps
`include "wwd_cfg.svh"
module wwd_core (
   input  wire logic               core_clk,
   input  wire logic               rst_n,
   input  wire wwd_pkg::wwd_addr_t reg_addr,
   input  wire wwd_pkg::wwd_byte_t reg_wdata,
   input  wire logic               reg_wr,
   input  wire logic               reg_rd,
   output wwd_pkg::wwd_byte_t      reg_rdata,
   input  wire wwd_pkg::wwd_mode_t watchdog_mode_fuse,
   input  wire wwd_pkg::wwd_ivl_t  fuse_interval,
   input  wire wwd_pkg::wwd_span_t fuse_open_span,
   input  wire logic               kick_instruction,
   input  wire logic               sleep_active,
   input  wire logic               settle_busy,
   input  wire logic               lf_tick,
   output logic                    wdt_reset_req,
   output logic                    wake_req
);
   import wwd_pkg::*;

   // control and status state
   wwd_ivl_t    interval_reg;
   logic        software_run_enable_reg;
   wwd_span_t   span_reg;
   logic        armed_reg;
   logic        sleep_reg;
   logic        span_violation_n_reg;
   logic        expiry_reset_cause_n_reg;
   logic        expiry_flag_n_reg;
   logic        sleep_flag_n_reg;
   logic        reset_req_reg;
   logic        wake_req_reg;
   wwd_byte_t   rdata_reg;
   wwd_byte_t   rdata_next;

   // decoded events
   logic        active;
   logic        wr_ctrl0;
   logic        wr_ctrl1;
   logic        wr_cause;
   logic        rd_ctrl0;
   logic        sleep_enter;
   logic        sleep_exit;
   logic        kick_seen;
   logic        kick_ok;
   logic        violation;
   logic        counter_clear;
   logic        expire;
   logic        span_open;
   logic        windowed;
   logic [2:0]  eighth;
   logic [22:0] count;

   // address decode shared by the write and read paths
   function automatic logic hit(input wwd_addr_t a, input wwd_addr_t want);
      hit = (a == want);
   endfunction : hit

   assign wr_ctrl0 = reg_wr && hit(reg_addr, `WWD_ADDR_CTRL0);
   assign wr_ctrl1 = reg_wr && hit(reg_addr, `WWD_ADDR_CTRL1);
   assign wr_cause = reg_wr && hit(reg_addr, `WWD_ADDR_CAUSE);
   assign rd_ctrl0 = reg_rd && hit(reg_addr, `WWD_ADDR_CTRL0);

   // operating mode from the fuse, sleep state and run enable
   always_comb begin
      case (watchdog_mode_fuse)
         `WWD_MODE_ALWAYS: active = 1'b1;
         `WWD_MODE_AWAKE:  active = !sleep_active;
         `WWD_MODE_SOFT:   active = software_run_enable_reg;
         `WWD_MODE_OFF:    active = 1'b0;
         default:          active = 1'b0;
      endcase
   end

   // sleep edges, seen in the same cycle the level moves
   always_ff @(posedge core_clk) begin
      if (!rst_n)
         sleep_reg <= 1'b0;
      else
         sleep_reg <= sleep_active;
   end
   assign sleep_enter = sleep_active && !sleep_reg;
   assign sleep_exit  = !sleep_active && sleep_reg;

   // kicks only count while the watchdog runs and the core is awake
   assign kick_seen = kick_instruction && active && !sleep_active;
   assign kick_ok   = !windowed || (armed_reg && span_open);
   assign violation = kick_seen && !kick_ok;

   // every event that restarts the period, our own reset included
   assign counter_clear = reset_req_reg || (kick_seen && kick_ok) ||
                          sleep_enter || sleep_exit || !active ||
                          settle_busy || wr_ctrl0 || wr_ctrl1;

   wwd_interval_timer u_timer (
      .core_clk      (core_clk),
      .rst_n         (rst_n),
      .clear         (counter_clear),
      .run           (active),
      .lf_tick       (lf_tick),
      .interval_code (interval_reg),
      .count         (count),
      .eighth        (eighth),
      .expire        (expire)
   );

   wwd_span_gate u_gate (
      .core_clk  (core_clk),
      .rst_n     (rst_n),
      .span_code (span_reg),
      .eighth    (eighth),
      .span_open (span_open),
      .windowed  (windowed)
   );

   // interval select: fuse value or default at reset, software-owned
   // only when the fuse leaves it open; our own reset reloads it too
   always_ff @(posedge core_clk) begin
      if (!rst_n || reset_req_reg) begin
         if (fuse_interval == `WWD_IVL_ALL_ONES)
            interval_reg <= `WWD_IVL_DEFAULT;
         else
            interval_reg <= fuse_interval;
      end else if (wr_ctrl0 && fuse_interval == `WWD_IVL_ALL_ONES) begin
         interval_reg <= reg_wdata[`WWD_C0_IVL_MSB:`WWD_C0_IVL_LSB];
      end
   end

   // software run enable always writable, read only matters in mode 01
   always_ff @(posedge core_clk) begin
      if (!rst_n || reset_req_reg)
         software_run_enable_reg <= 1'b0;
      else if (wr_ctrl0)
         software_run_enable_reg <= reg_wdata[`WWD_C0_RUN_BIT];
   end

   // open span select: fuse value, software-owned only if fuse is 111
   always_ff @(posedge core_clk) begin
      if (!rst_n || reset_req_reg)
         span_reg <= fuse_open_span;
      else if (wr_ctrl1 && fuse_open_span == `WWD_SPAN_FULL)
         span_reg <= reg_wdata[2:0];
   end

   // arming: a read of control zero arms; any counter clear disarms,
   // and a clear in the same cycle wins so a new period needs a new read
   always_ff @(posedge core_clk) begin
      if (!rst_n)
         armed_reg <= 1'b0;
      else if (counter_clear)
         armed_reg <= 1'b0;
      else if (rd_ctrl0)
         armed_reg <= 1'b1;
   end

   // reset and wake requests, one cycle each
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         reset_req_reg <= 1'b0;
         wake_req_reg  <= 1'b0;
      end else begin
         reset_req_reg <= violation ||
                          (expire && !sleep_active);
         wake_req_reg  <= expire && sleep_active;
      end
   end
   assign wdt_reset_req = reset_req_reg;
   assign wake_req      = wake_req_reg;

   // span violation flag: hardware clear beats a firmware set
   always_ff @(posedge core_clk) begin
      if (!rst_n)
         span_violation_n_reg <= 1'b1;
      else if (violation)
         span_violation_n_reg <= 1'b0;
      else if (wr_cause && reg_wdata[`WWD_CA_SPAN_BIT])
         span_violation_n_reg <= 1'b1;
   end

   // watchdog reset cause: marked by any expiry, sleep included
   always_ff @(posedge core_clk) begin
      if (!rst_n)
         expiry_reset_cause_n_reg <= 1'b1;
      else if (expire)
         expiry_reset_cause_n_reg <= 1'b0;
      else if (wr_cause && reg_wdata[`WWD_CA_WDRST_BIT])
         expiry_reset_cause_n_reg <= 1'b1;
   end

   // expiry and power-down flags; a sleep expiry drops both
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         expiry_flag_n_reg <= 1'b1;
         sleep_flag_n_reg  <= 1'b1;
      end else if (expire) begin
         expiry_flag_n_reg <= 1'b0;
         sleep_flag_n_reg  <= !sleep_active;
      end else if (wr_cause) begin
         if (reg_wdata[`WWD_CA_EXPIRY_BIT])
            expiry_flag_n_reg <= 1'b1;
         if (reg_wdata[`WWD_CA_SLEEP_BIT])
            sleep_flag_n_reg <= 1'b1;
      end
   end

   // read mux; unmapped words and reserved bits read as zero
   always_comb begin
      rdata_next = 8'h00;
      case (reg_addr)
         `WWD_ADDR_CTRL0: begin
            rdata_next[`WWD_C0_IVL_MSB:`WWD_C0_IVL_LSB] = interval_reg;
            rdata_next[`WWD_C0_RUN_BIT] = software_run_enable_reg;
         end
         `WWD_ADDR_CTRL1: begin
            rdata_next[2:0] = span_reg;
         end
         `WWD_ADDR_STATUS: begin
            rdata_next[`WWD_ST_ARMED_BIT]  = armed_reg;
            rdata_next[`WWD_ST_ASLEEP_BIT] = sleep_active;
            rdata_next[`WWD_ST_ACTIVE_BIT] = active;
         end
         `WWD_ADDR_CAUSE: begin
            rdata_next[`WWD_CA_SPAN_BIT]   = span_violation_n_reg;
            rdata_next[`WWD_CA_WDRST_BIT]  = expiry_reset_cause_n_reg;
            rdata_next[`WWD_CA_EXPIRY_BIT] = expiry_flag_n_reg;
            rdata_next[`WWD_CA_SLEEP_BIT]  = sleep_flag_n_reg;
         end
         default: rdata_next = 8'h00;
      endcase
   end

   // read data stands only in the cycle after the strobe
   always_ff @(posedge core_clk) begin
      if (!rst_n)
         rdata_reg <= 8'h00;
      else if (reg_rd)
         rdata_reg <= rdata_next;
      else
         rdata_reg <= 8'h00;
   end
   assign reg_rdata = rdata_reg;

   // checks on mode, window, arming, clearing and sleep behaviour
   sequence s_bad_kick;
      kick_seen && !kick_ok;
   endsequence

   sequence s_unarmed_kick;
      kick_seen && windowed && !armed_reg;
   endsequence

   sequence s_sleep_expiry;
      expire && sleep_active;
   endsequence

   // a tick in sleep must still move the counter or end the period
   always_on_a: assert property (
      @(posedge core_clk) disable iff (!rst_n)
      (watchdog_mode_fuse == `WWD_MODE_ALWAYS && sleep_active &&
       lf_tick && !counter_clear) |=> (count != 23'h0 || expire))
      else $error("always-on mode not counting");

   sleep_off_a: assert property (
      @(posedge core_clk) disable iff (!rst_n)
      (watchdog_mode_fuse == `WWD_MODE_AWAKE && sleep_active) |=>
      count == 23'h0)
      else $error("counter moved in sleep with awake-only mode");

   soft_ctrl_a: assert property (
      @(posedge core_clk) disable iff (!rst_n)
      (watchdog_mode_fuse == `WWD_MODE_SOFT) |->
      active == software_run_enable_reg)
      else $error("software mode ignores the run enable");

   mode_off_a: assert property (
      @(posedge core_clk) disable iff (!rst_n)
      (watchdog_mode_fuse == `WWD_MODE_OFF) |->
      !active ##1 !wdt_reset_req)
      else $error("off mode still active");

   bad_kick_a: assert property (
      @(posedge core_clk) disable iff (!rst_n)
      s_bad_kick |=> wdt_reset_req && !span_violation_n_reg)
      else $error("window violation did not reset");

   unarmed_kick_a: assert property (
      @(posedge core_clk) disable iff (!rst_n)
      s_unarmed_kick |=> wdt_reset_req ##1 !wdt_reset_req)
      else $error("unarmed kick accepted");

   ivl_readonly_a: assert property (
      @(posedge core_clk) disable iff (!rst_n)
      (wr_ctrl0 && fuse_interval != `WWD_IVL_ALL_ONES &&
       !reset_req_reg) |=> $stable(interval_reg))
      else $error("locked interval changed by a write");

   write_clear_a: assert property (
      @(posedge core_clk) disable iff (!rst_n)
      (wr_ctrl0 || wr_ctrl1) |=> count == 23'h0 && !armed_reg)
      else $error("control write left counter running");

   sleep_wake_a: assert property (
      @(posedge core_clk) disable iff (!rst_n)
      s_sleep_expiry |=> wake_req && !wdt_reset_req &&
      !expiry_flag_n_reg && !sleep_flag_n_reg)
      else $error("sleep expiry did not wake cleanly");

   awake_exp_a: assert property (
      @(posedge core_clk) disable iff (!rst_n)
      (expire && !sleep_active) |=> wdt_reset_req && !wake_req)
      else $error("awake expiry did not reset");

   settle_hold_a: assert property (
      @(posedge core_clk) disable iff (!rst_n)
      settle_busy |=> count == 23'h0)
      else $error("counter moved while oscillator settles");
endmodule : wwd_core

// ==== core/wwd_interval_timer.sv ====
// Purpose: prescaled counter of low-frequency ticks with expiry pulse
// Assumes: lf_tick is a one-cycle pulse per low-frequency period
// Notes:   one counter serves as prescaler and period counter
`timescale 1ns/1ps
`include "wwd_cfg.svh"
module wwd_interval_timer (
   input  wire logic              core_clk,
   input  wire logic              rst_n,
   input  wire logic              clear,
   input  wire logic              run,
   input  wire logic              lf_tick,
   input  wire wwd_pkg::wwd_ivl_t interval_code,
   output logic [22:0]            count,
   output logic [2:0]             eighth,
   output logic                   expire
);
   import wwd_pkg::*;

   logic [22:0] count_reg;
   logic [22:0] count_next;
   logic        expire_reg;
   logic [4:0]  shift;
   logic        at_last;

   // reserved codes fall back to the shortest interval
   function automatic logic [4:0] ivl_shift(input wwd_ivl_t code);
      if (code > `WWD_IVL_MAX_VALID)
         ivl_shift = `WWD_IVL_MIN + `WWD_IVL_BASE_SHIFT;
      else
         ivl_shift = code + `WWD_IVL_BASE_SHIFT;
   endfunction : ivl_shift

   // last count of a period of 2^shift ticks
   function automatic logic [22:0] last_of(input logic [4:0] s);
      logic [23:0] full;
      full    = 24'h1 << s;
      last_of = 23'(full - 24'h1);
   endfunction : last_of

   assign shift   = ivl_shift(interval_code);
   assign at_last = (count_reg == last_of(shift));
   assign eighth  = 3'(count_reg >> (shift - `WWD_EIGHTH_SHIFT));
   assign count   = count_reg;
   assign expire  = expire_reg;

   // counts ticks of the slow time base only, so oscillator divider
   // changes of the core clock leave it alone
   always_comb begin
      count_next = count_reg;
      if (clear || !run)
         count_next = 23'h0;
      else if (lf_tick)
         count_next = at_last ? 23'h0 : count_reg + 23'h1;
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n)
         count_reg <= 23'h0;
      else
         count_reg <= count_next;
   end

   // expiry pulse one cycle after the last tick
   always_ff @(posedge core_clk) begin
      if (!rst_n)
         expire_reg <= 1'b0;
      else
         expire_reg <= run && !clear && lf_tick && at_last;
   end

   sequence s_last_tick;
      run && !clear && lf_tick && at_last;
   endsequence
   expire_time_a: assert property (
      @(posedge core_clk) disable iff (!rst_n)
      s_last_tick |=> expire && count_reg == 23'h0)
      else $error("expiry not at end of period");
endmodule : wwd_interval_timer

// ==== core/wwd_pkg.sv ====
// Purpose: shared types of the windowed watchdog
// Assumes: constants live in wwd_cfg.svh
// Notes:   types only
package wwd_pkg;
   typedef logic [7:0] wwd_byte_t;
   typedef logic [2:0] wwd_addr_t;
   typedef logic [1:0] wwd_mode_t;
   typedef logic [4:0] wwd_ivl_t;
   typedef logic [2:0] wwd_span_t;
endpackage : wwd_pkg

// ==== core/wwd_span_gate.sv ====
// Purpose: decides whether a kick lands in the open part of the period
// Assumes: eighth is the elapsed share of the period in eighths
// Notes:   closed delay first, open share at the end
`timescale 1ns/1ps
`include "wwd_cfg.svh"
module wwd_span_gate (
   input  wire logic           core_clk,
   input  wire logic           rst_n,
   input  wire wwd_pkg::wwd_span_t span_code,
   input  wire logic [2:0]     eighth,
   output logic                span_open,
   output logic                windowed
);
   import wwd_pkg::*;

   // open when the delay share (7 - code eighths) has passed
   assign windowed  = (span_code != `WWD_SPAN_FULL);
   assign span_open = !windowed ||
                      (eighth >= (`WWD_SPAN_FULL - span_code));

   // smallest share: only the last eighth is open
   property p_small_share;
      @(posedge core_clk) disable iff (!rst_n)
      (span_code == 3'h0 && eighth != 3'h7) |-> !span_open;
   endproperty
   small_share_a: assert property (p_small_share)
      else $error("closed share opened early");

   // full code never closes
   full_open_a: assert property (
      @(posedge core_clk) disable iff (!rst_n)
      (span_code == `WWD_SPAN_FULL) |-> span_open)
      else $error("full span code closed the window");
endmodule : wwd_span_gate

// ==== test/wwd_core_tb.sv ====
// Purpose: self-checking bench for the windowed watchdog core
// Assumes: lf_tick pulsed by the bench; one event pulse per expiry
// Notes:   inputs change at rising edges, events counted on falling edges
`timescale 1ns/1ps
module wwd_core_tb;
   import wwd_pkg::*;
   logic       core_clk;
   logic       rst_n;
   wwd_addr_t  reg_addr;
   wwd_byte_t  reg_wdata;
   logic       reg_wr;
   logic       reg_rd;
   wwd_byte_t  reg_rdata;
   wwd_mode_t  watchdog_mode_fuse;
   wwd_ivl_t   fuse_interval;
   wwd_span_t  fuse_open_span;
   logic       kick_instruction;
   logic       sleep_active;
   logic       settle_busy;
   logic       lf_tick;
   logic       wdt_reset_req;
   logic       wake_req;
   int         mismatches;
   int         check_count;
   int         rst_seen;
   int         wake_seen;

   wwd_core dut_u (
      .core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .watchdog_mode_fuse(watchdog_mode_fuse),
      .fuse_interval(fuse_interval), .fuse_open_span(fuse_open_span),
      .kick_instruction(kick_instruction), .sleep_active(sleep_active),
      .settle_busy(settle_busy), .lf_tick(lf_tick),
      .wdt_reset_req(wdt_reset_req), .wake_req(wake_req)
   );

   // 50 MHz core clock
   initial begin
      core_clk = 1'b0;
      forever #10 core_clk = ~core_clk;
   end

   // pulses counted mid-cycle so the tally never races the edge
   always @(negedge core_clk) begin
      if (wdt_reset_req === 1'b1) rst_seen++;
      if (wake_req === 1'b1) wake_seen++;
   end

   task automatic check_byte(input wwd_byte_t got, input wwd_byte_t exp);
      check_count++;
      if (got !== exp) begin
         mismatches++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : check_byte

   task automatic check_num(input int got, input int exp);
      check_count++;
      if (got !== exp) begin
         mismatches++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : check_num

   task automatic give_verdict();
      $display("checks %0d mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : give_verdict

   task automatic wait_n(input int n);
      repeat (n) @(posedge core_clk);
   endtask : wait_n

   // reset held four cycles; fuses are sampled while it is low
   task automatic do_reset();
      rst_n <= 1'b0;
      wait_n(4);
      rst_n <= 1'b1;
      wait_n(1);
   endtask : do_reset

   // every bus task starts and ends at a rising edge
   task automatic reg_write(input wwd_addr_t a, input wwd_byte_t d);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge core_clk) reg_wr <= 1'b0;
      wait_n(1);
   endtask : reg_write

   task automatic reg_read(input wwd_addr_t a, output wwd_byte_t d);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge core_clk) reg_rd <= 1'b0;
      // data stand in the cycle after the strobe; take them at its end
      @(posedge core_clk) d = reg_rdata;
   endtask : reg_read

   task automatic tick(input int n);
      repeat (n) begin
         lf_tick <= 1'b1;
         @(posedge core_clk) lf_tick <= 1'b0;
         wait_n(1);
      end
   endtask : tick

   task automatic kick();
      kick_instruction <= 1'b1;
      @(posedge core_clk) kick_instruction <= 1'b0;
      wait_n(1);
   endtask : kick

   task automatic set_env(input wwd_mode_t m, input logic s);
      watchdog_mode_fuse <= m;
      sleep_active       <= s;
      wait_n(3);
   endtask : set_env

   task automatic test_regs();
      wwd_byte_t d;
      reg_read(3'h0, d);
      check_byte(d, 8'h16);
      reg_read(3'h1, d);
      check_byte(d, 8'h07);
      reg_read(3'h3, d);
      check_byte(d, 8'h0f);
      reg_write(3'h6, 8'hff);
      reg_read(3'h6, d);
      check_byte(d, 8'h00);
      reg_write(3'h0, 8'h25);
      reg_read(3'h0, d);
      check_byte(d, 8'h25);
      fuse_interval  <= 5'h03;
      fuse_open_span <= 3'h3;
      do_reset();
      reg_read(3'h0, d);
      check_byte(d, 8'h06);
      reg_write(3'h0, 8'h3f);
      reg_read(3'h0, d);
      check_byte(d, 8'h07);
      reg_write(3'h1, 8'h07);
      reg_read(3'h1, d);
      check_byte(d, 8'h03);
      fuse_interval  <= 5'h1f;
      fuse_open_span <= 3'h7;
      do_reset();
      $display("test regs done");
   endtask : test_regs

   task automatic test_expiry();
      wwd_ivl_t  codes[4] = '{5'h00, 5'h01, 5'h13, 5'h1f};
      wwd_byte_t d;
      int        len;
      int        base;
      set_env(2'h2, 1'b0);
      reg_write(3'h3, 8'h0f);
      foreach (codes[i]) begin
         len = (codes[i] <= 5'h12) ? (32 << codes[i]) : 32;
         reg_write(3'h0, {2'b00, codes[i], 1'b0});
         base = rst_seen;
         tick(len - 1);
         wait_n(4);
         check_num(rst_seen, base);
         tick(1);
         wait_n(4);
         check_num(rst_seen, base + 1);
      end
      reg_read(3'h3, d);
      check_byte(d, 8'h09);
      // counter must stay at zero while the settle timer runs
      reg_write(3'h0, 8'h00);
      base = rst_seen;
      settle_busy <= 1'b1;
      tick(40);
      wait_n(4);
      check_num(rst_seen, base);
      settle_busy <= 1'b0;
      tick(32);
      wait_n(4);
      check_num(rst_seen, base + 1);
      $display("test expiry done");
   endtask : test_expiry

   task automatic test_modes();
      // row: mode[4:3] sleep[2] run[1] active[0]
      logic [4:0] rows[8] = '{5'h1d, 5'h11, 5'h14, 5'h0b,
                              5'h0f, 5'h08, 5'h02, 5'h06};
      wwd_byte_t  d;
      int         br;
      int         bw;
      foreach (rows[i]) begin
         set_env(rows[i][4:3], rows[i][2]);
         reg_write(3'h0, {7'h00, rows[i][1]});
         reg_read(3'h2, d);
         check_byte(d, {6'h00, rows[i][2], rows[i][0]});
         br = rst_seen;
         bw = wake_seen;
         tick(32);
         wait_n(4);
         check_num(rst_seen, br + int'(rows[i][0] & ~rows[i][2]));
         check_num(wake_seen, bw + int'(rows[i][0] & rows[i][2]));
      end
      set_env(2'h2, 1'b0);
      reg_read(3'h3, d);
      check_byte(d, 8'h08);
      $display("test modes done");
   endtask : test_modes

   // half-open window: closed for the first sixteen ticks of 32
   task automatic win_setup();
      reg_write(3'h0, 8'h00);
      reg_write(3'h1, 8'h03);
   endtask : win_setup

   task automatic test_window();
      wwd_byte_t d;
      int        base;
      set_env(2'h2, 1'b0);
      reg_write(3'h3, 8'h0f);
      base = rst_seen;
      win_setup();
      kick();
      wait_n(4);
      check_num(rst_seen, base + 1);
      reg_read(3'h3, d);
      check_byte(d & 8'h08, 8'h00);
      reg_write(3'h3, 8'h08);
      reg_read(3'h3, d);
      check_byte(d & 8'h08, 8'h08);
      win_setup();
      reg_read(3'h0, d);
      reg_read(3'h2, d);
      check_byte(d, 8'h05);
      tick(15);
      kick();
      wait_n(4);
      check_num(rst_seen, base + 2);
      win_setup();
      reg_read(3'h0, d);
      tick(16);
      kick();
      wait_n(4);
      check_num(rst_seen, base + 2);
      reg_read(3'h2, d);
      check_byte(d, 8'h01);
      tick(20);
      wait_n(4);
      check_num(rst_seen, base + 2);
      kick();
      wait_n(4);
      check_num(rst_seen, base + 3);
      $display("test window done");
   endtask : test_window

   // hang guard, far beyond the under two thousand cycles the tests need
   initial begin
      wait_n(20000);
      mismatches++;
      give_verdict();
   end

   initial begin
      rst_n = 1'b0;
      reg_addr = 3'h0;
      reg_wdata = 8'h00;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      watchdog_mode_fuse = 2'h2;
      fuse_interval = 5'h1f;
      fuse_open_span = 3'h7;
      kick_instruction = 1'b0;
      sleep_active = 1'b0;
      settle_busy = 1'b0;
      lf_tick = 1'b0;
      mismatches = 0;
      check_count = 0;
      rst_seen = 0;
      wake_seen = 0;
      do_reset();
      test_regs();
      test_expiry();
      test_modes();
      test_window();
      give_verdict();
   end
endmodule : wwd_core_tb
